// File: hdl/cfgrom_pkg.sv
// Constants and types shared by the configuration EEPROM interface
package cfgrom_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS_CONFIG  = 16'h0500;
    localparam logic [15:0] OFS_ACCESS  = 16'h0501;
    localparam logic [15:0] OFS_CTRL_LO = 16'h0502;
    localparam logic [15:0] OFS_CTRL_HI = 16'h0503;
    localparam logic [15:0] OFS_ADDR    = 16'h0504;
    localparam logic [15:0] OFS_DATA    = 16'h0508;

    // ------------------------------------------------------------------
    // Field positions (bit within the byte)
    // ------------------------------------------------------------------
    localparam int CFG_OFFER_BIT = 0;
    localparam int CFG_FORCE_BIT = 1;
    localparam int ACC_TAKE_BIT  = 0;
    localparam int CTL_WE_BIT    = 0;
    localparam int CTL_EMUL_BIT  = 5;
    localparam int CTL_RD8_BIT   = 6;
    localparam int CTL_ALG_BIT   = 7;
    localparam int HI_CMD_LSB    = 0;
    localparam int HI_CKSUM_BIT  = 3;
    localparam int HI_LOAD_BIT   = 4;
    localparam int HI_ACKERR_BIT = 5;
    localparam int HI_WEERR_BIT  = 6;
    localparam int HI_BUSY_BIT   = 7;

    // ------------------------------------------------------------------
    // Commands, reset values and bus constants
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_IDLE   = 3'h0;
    localparam logic [2:0] CMD_READ   = 3'h1;
    localparam logic [2:0] CMD_WRITE  = 3'h2;
    localparam logic [2:0] CMD_RELOAD = 3'h4;
    localparam logic       RST_LOADING = 1'h1;
    localparam logic [6:0] DEV_ADDR    = 7'h50; // Serial memory bus address

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int I2C_BIT_NS    = 10000;
    localparam int QTR_CYC       = I2C_BIT_NS / (4 * CLK_PERIOD_NS);
    localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_START   = 3'b001,
        ST_BYTE    = 3'b011,
        ST_STOP    = 3'b010,
        ST_EMUL    = 3'b110
    } ctl_state_e;

    // Complete register state of the interface
    typedef struct packed {
        ctl_state_e  state;
        logic [8:0]  qcnt;
        logic [1:0]  qtr;
        logic [3:0]  bitn;
        logic [3:0]  bcnt;
        logic        rdph;
        logic        nack;
        logic [7:0]  shreg;
        logic [7:0]  xsum;
        logic        scl_oe;
        logic        sda_oe;
        logic        sda_s1;
        logic        sda_s2;
        logic [7:0]  cfg;
        logic        host_acc;
        logic        we;
        logic [2:0]  cmd;
        logic        ack_err;
        logic        we_err;
        logic        busy;
        logic        loading;
        logic        cksum_err;
        logic        event_req;
        logic [31:0] addr;
        logic [63:0] data;
        logic [7:0]  net_rdata;
        logic [7:0]  host_rdata;
    } state_s;

    // Byte-wide register write/address request of one side
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_s;
endpackage

// File: hdl/config_eeprom_interface.sv
// Configuration EEPROM interface: ownership, commands, serial engine
`timescale 1ns/10ps
module config_eeprom_interface (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire cfgrom_pkg::reg_req_s net_bus_i,
    output logic [7:0]                net_rdata_o,
    input  wire cfgrom_pkg::reg_req_s host_bus_i,
    output logic [7:0]                host_rdata_o,
    input  wire logic                 frame_sof_i,
    input  wire logic                 emul_mode_i,
    input  wire logic                 read8_i,
    input  wire logic                 addr2_i,
    output logic                      scl_o,
    output logic                      scl_oe_o,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    output logic                      event_req_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cfgrom_pkg::state_s   r;
    cfgrom_pkg::state_s   n;

    logic                 host_owns;
    logic                 we_eff;
    logic                 tick;
    logic                 rx;
    logic                 last_rx;
    logic [3:0]           nrd;
    logic [3:0]           ntx;
    logic [3:0]           nb;
    logic [18:0]          ba;
    logic [7:0]           dev;
    logic [39:0]          txl;
    cfgrom_pkg::reg_req_s own;

    // ------------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == cfgrom_pkg::OFS_CONFIG) begin
            v = r.cfg;
        end else if (a == cfgrom_pkg::OFS_ACCESS) begin
            v[cfgrom_pkg::ACC_TAKE_BIT] = r.host_acc;
        end else if (a == cfgrom_pkg::OFS_CTRL_LO) begin
            v[cfgrom_pkg::CTL_WE_BIT]   = we_eff;
            v[cfgrom_pkg::CTL_EMUL_BIT] = emul_mode_i;
            v[cfgrom_pkg::CTL_RD8_BIT]  = read8_i;
            v[cfgrom_pkg::CTL_ALG_BIT]  = addr2_i;
        end else if (a == cfgrom_pkg::OFS_CTRL_HI) begin
            v[cfgrom_pkg::HI_CMD_LSB +: 3]  = r.cmd;
            v[cfgrom_pkg::HI_CKSUM_BIT]     = r.cksum_err;
            v[cfgrom_pkg::HI_LOAD_BIT]      = r.loading;
            v[cfgrom_pkg::HI_ACKERR_BIT]    = r.ack_err;
            v[cfgrom_pkg::HI_WEERR_BIT]     = r.we_err;
            v[cfgrom_pkg::HI_BUSY_BIT]      = r.busy;
        end else if (a[15:2] == cfgrom_pkg::OFS_ADDR[15:2]) begin
            v = r.addr[8*a[1:0] +: 8];
        end else if (a[15:3] == cfgrom_pkg::OFS_DATA[15:3]) begin
            v = r.data[8*a[2:0] +: 8];
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Derived terms of ownership and of the serial sequence
    // ------------------------------------------------------------------
    always_comb begin
        host_owns = r.cfg[cfgrom_pkg::CFG_OFFER_BIT] & r.host_acc;
        we_eff    = host_owns | r.we;
        own       = host_owns ? host_bus_i : net_bus_i;
        tick      = (r.qcnt == cfgrom_pkg::QTR_LAST);
        rx        = r.rdph && (r.bcnt != 4'h0);
        nrd       = read8_i ? 4'h8 : 4'h4;
        last_rx   = r.rdph && (r.bcnt == nrd);
        ntx       = (r.cmd == cfgrom_pkg::CMD_WRITE) ?
                    (addr2_i ? 4'h5 : 4'h4) : (addr2_i ? 4'h3 : 4'h2);
        nb        = r.bcnt + 4'h1;
        // Word address to byte address; reload starts at word zero
        ba = (r.cmd == cfgrom_pkg::CMD_RELOAD) ? 19'h00000 :
             (addr2_i ? {r.addr[17:0], 1'b0}
                      : {8'h00, r.addr[9:0], 1'b0});
        dev = {cfgrom_pkg::DEV_ADDR[6:3],
               addr2_i ? ba[18:16] : ba[10:8], r.rdph};
        txl = addr2_i ? {r.data[15:8], r.data[7:0], ba[7:0], ba[15:8], dev}
                      : {8'h00, r.data[15:8], r.data[7:0], ba[7:0], dev};
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        n            = r;
        n.sda_s1     = sda_i;
        n.sda_s2     = r.sda_s1;
        n.net_rdata  = rd_byte(net_bus_i.addr);
        n.host_rdata = rd_byte(host_bus_i.addr);

        // Frame start drops the write permission
        if (frame_sof_i) begin
            n.we = 1'b0;
        end

        // Host take/release of the interface
        if (host_bus_i.wr && host_bus_i.addr == cfgrom_pkg::OFS_ACCESS &&
            r.cfg[cfgrom_pkg::CFG_OFFER_BIT] &&
            !r.cfg[cfgrom_pkg::CFG_FORCE_BIT]) begin
            n.host_acc = host_bus_i.wdata[cfgrom_pkg::ACC_TAKE_BIT];
        end

        // Network configuration byte
        if (net_bus_i.wr && net_bus_i.addr == cfgrom_pkg::OFS_CONFIG) begin
            n.cfg = net_bus_i.wdata;
            if (net_bus_i.wdata[cfgrom_pkg::CFG_FORCE_BIT]) begin
                n.host_acc = 1'b0;
            end
        end

        // Owner writes while idle
        if (own.wr && !r.busy) begin
            if (own.addr == cfgrom_pkg::OFS_CTRL_LO && !host_owns) begin
                n.we = own.wdata[cfgrom_pkg::CTL_WE_BIT];
            end else if (own.addr == cfgrom_pkg::OFS_CTRL_HI) begin
                case (own.wdata[2:0])
                    cfgrom_pkg::CMD_IDLE: begin
                        n.ack_err = 1'b0;
                        n.we_err  = 1'b0;
                    end
                    cfgrom_pkg::CMD_READ, cfgrom_pkg::CMD_WRITE,
                    cfgrom_pkg::CMD_RELOAD: begin
                        if (!r.ack_err) begin
                            n.ack_err = 1'b0;
                            n.we_err  = 1'b0;
                            if (own.wdata[2:0] == cfgrom_pkg::CMD_WRITE &&
                                !we_eff) begin
                                n.we_err = 1'b1;
                            end else begin
                                n.cmd   = own.wdata[2:0];
                                n.busy  = 1'b1;
                                n.rdph  = 1'b0;
                                n.bcnt  = 4'h0;
                                n.qtr   = 2'h0;
                                n.qcnt  = 9'h000;
                                n.xsum  = 8'h00;
                                if (own.wdata[2:0] == cfgrom_pkg::CMD_RELOAD)
                                begin
                                    n.loading = 1'b1;
                                end
                                if (emul_mode_i) begin
                                    n.state     = cfgrom_pkg::ST_EMUL;
                                    n.event_req = 1'b1;
                                end else begin
                                    n.state = cfgrom_pkg::ST_START;
                                end
                            end
                        end
                    end
                    default: begin
                        if (!r.ack_err) begin
                            n.ack_err = 1'b1;
                        end
                    end
                endcase
            end else if (own.addr[15:2] == cfgrom_pkg::OFS_ADDR[15:2]) begin
                n.addr[8*own.addr[1:0] +: 8] = own.wdata;
            end else if (own.addr[15:3] == cfgrom_pkg::OFS_DATA[15:3] &&
                         own.addr[2:1] == 2'h0) begin
                n.data[8*own.addr[2:0] +: 8] = own.wdata;
            end
        end

        // Emulating host answers a pending command
        if (host_bus_i.wr && r.state == cfgrom_pkg::ST_EMUL) begin
            if (host_bus_i.addr == cfgrom_pkg::OFS_CTRL_HI &&
                ((host_bus_i.wdata[2:0] & r.cmd) != 3'h0 ||
                 host_bus_i.wdata[cfgrom_pkg::HI_ACKERR_BIT])) begin
                n.ack_err   = host_bus_i.wdata[cfgrom_pkg::HI_ACKERR_BIT];
                n.event_req = 1'b0;
                n.busy      = 1'b0;
                n.cmd       = cfgrom_pkg::CMD_IDLE;
                n.state     = cfgrom_pkg::ST_IDLE;
                if (r.cmd == cfgrom_pkg::CMD_RELOAD) begin
                    n.loading = host_bus_i.wdata[cfgrom_pkg::HI_ACKERR_BIT];
                end
            end else if (host_bus_i.addr[15:3] == cfgrom_pkg::OFS_DATA[15:3] &&
                         r.cmd != cfgrom_pkg::CMD_WRITE) begin
                n.data[8*host_bus_i.addr[2:0] +: 8] = host_bus_i.wdata;
            end
        end

        // Serial engine: four quarter periods per bit
        if (r.state == cfgrom_pkg::ST_START || r.state == cfgrom_pkg::ST_BYTE ||
            r.state == cfgrom_pkg::ST_STOP) begin
            n.qcnt = tick ? 9'h000 : r.qcnt + 9'h001;
            if (tick) begin
                n.qtr = r.qtr + 2'h1;
            end
        end
        if (tick) begin
            case (r.state)
                cfgrom_pkg::ST_START: begin
                    case (r.qtr)
                        2'h0: n.sda_oe = 1'b0;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b1;
                        default: begin
                            n.scl_oe = 1'b1;
                            n.state  = cfgrom_pkg::ST_BYTE;
                            n.bitn   = 4'h0;
                            n.nack   = 1'b0;
                            n.shreg  = dev;
                        end
                    endcase
                end
                cfgrom_pkg::ST_BYTE: begin
                    case (r.qtr)
                        2'h0: begin
                            if (r.bitn != 4'h8) begin
                                n.sda_oe = rx ? 1'b0 : ~r.shreg[7];
                            end else begin
                                n.sda_oe = rx && !last_rx;
                            end
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.bitn != 4'h8) begin
                                n.shreg = {r.shreg[6:0], r.sda_s2};
                            end else if (!rx) begin
                                n.nack = r.sda_s2;
                            end
                        end
                        default: begin
                            n.scl_oe = 1'b1;
                            n.bitn   = r.bitn + 4'h1;
                            if (r.bitn == 4'h8) begin
                                n.bitn = 4'h0;
                                if (rx) begin
                                    n.data[8*(3'(r.bcnt - 4'h1)) +: 8] =
                                        r.shreg;
                                    n.xsum = r.xsum ^ r.shreg;
                                end
                                if (r.nack) begin
                                    n.ack_err = 1'b1;
                                    n.state   = cfgrom_pkg::ST_STOP;
                                end else if (!r.rdph && nb < ntx) begin
                                    n.bcnt  = nb;
                                    n.shreg = txl[8*nb[2:0] +: 8];
                                end else if (!r.rdph &&
                                    r.cmd != cfgrom_pkg::CMD_WRITE) begin
                                    n.rdph  = 1'b1;
                                    n.bcnt  = 4'h0;
                                    n.state = cfgrom_pkg::ST_START;
                                end else if (r.rdph && nb <= nrd) begin
                                    n.bcnt  = nb;
                                    n.shreg = 8'hff;
                                end else begin
                                    n.state = cfgrom_pkg::ST_STOP;
                                end
                            end
                        end
                    endcase
                end
                cfgrom_pkg::ST_STOP: begin
                    case (r.qtr)
                        2'h0: n.sda_oe = 1'b1;
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: n.sda_oe = 1'b0;
                        default: begin
                            n.state = cfgrom_pkg::ST_IDLE;
                            n.busy  = 1'b0;
                            n.cmd   = cfgrom_pkg::CMD_IDLE;
                            if (r.cmd == cfgrom_pkg::CMD_RELOAD) begin
                                n.loading   = r.ack_err | (r.xsum != 8'h00);
                                n.cksum_err = (r.xsum != 8'h00);
                            end
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r         <= '0;
            r.state   <= cfgrom_pkg::ST_IDLE;
            r.loading <= cfgrom_pkg::RST_LOADING;
            r.sda_s1  <= 1'b1;
            r.sda_s2  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Open-drain pins drive low only
    assign scl_o        = 1'b0;
    assign sda_o        = 1'b0;
    assign scl_oe_o     = r.scl_oe;
    assign sda_oe_o     = r.sda_oe;
    assign net_rdata_o  = r.net_rdata;
    assign host_rdata_o = r.host_rdata;
    assign event_req_o  = r.event_req;
endmodule // config_eeprom_interface

// File: sim/config_eeprom_interface_assertions.sv
// Port-level checks for the configuration EEPROM interface
`timescale 1ns/10ps
module config_eeprom_interface_assertions (
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    input wire cfgrom_pkg::reg_req_s net_bus_i,
    input wire logic [7:0]           net_rdata_o,
    input wire cfgrom_pkg::reg_req_s host_bus_i,
    input wire logic [7:0]           host_rdata_o,
    input wire logic                 frame_sof_i,
    input wire logic                 emul_mode_i,
    input wire logic                 read8_i,
    input wire logic                 addr2_i,
    input wire logic                 scl_o,
    input wire logic                 scl_oe_o,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe_o,
    input wire logic                 event_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence s_start;
        $rose(sda_oe_o) && !scl_oe_o;
    endsequence
    sequence s_host_cfg_wr;
        host_bus_i.wr && host_bus_i.addr == 16'h0500
        && net_bus_i.addr == 16'h0500 ##1 net_bus_i.addr == 16'h0500;
    endsequence
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_idle_after_reset: assert property ($fell(sys_rst_i) |->
        !scl_oe_o && !sda_oe_o && !event_req_o && net_rdata_o == 8'h00)
        else $error("outputs not idle after reset");
    a_loading_set: assert property ($fell(sys_rst_i)
        && net_bus_i.addr == 16'h0503 |=> net_rdata_o == 8'h10)
        else $error("status byte wrong after reset");
    a_strap_bits: assert property (net_bus_i.addr == 16'h0502 |=>
        net_rdata_o[7:5] == $past({addr2_i, read8_i, emul_mode_i}))
        else $error("strap bits misreported");
    a_emul_quiet: assert property (emul_mode_i && $past(emul_mode_i)
        |-> !scl_oe_o && !sda_oe_o)
        else $error("serial bus driven while emulating");
    a_event_emul: assert property ($rose(event_req_o) |->
        $past(emul_mode_i)) else $error("event outside emulation");
    a_event_error_ack: assert property (event_req_o && host_bus_i.wr
        && host_bus_i.addr == 16'h0503 && host_bus_i.wdata[5]
        |=> !event_req_o) else $error("error acknowledge kept event");
    a_start_clock: assert property (s_start |-> ##[1:1000] scl_oe_o)
        else $error("no clock after start");
    a_host_cfg_ro: assert property (s_host_cfg_wr |=>
        $stable(net_rdata_o)) else $error("host changed config byte");
endmodule // config_eeprom_interface_assertions

bind config_eeprom_interface config_eeprom_interface_assertions chk_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .net_bus_i(net_bus_i),
    .net_rdata_o(net_rdata_o), .host_bus_i(host_bus_i),
    .host_rdata_o(host_rdata_o), .frame_sof_i(frame_sof_i),
    .emul_mode_i(emul_mode_i), .read8_i(read8_i), .addr2_i(addr2_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .event_req_o(event_req_o));

// File: sim/eeprom_model.sv
// Serial memory model that acknowledges only when enabled
`timescale 1ns/10ps
module eeprom_model (
    input  wire logic  scl_i,
    input  wire logic  sda_i,
    input  wire logic  ack_en_i,
    output logic       pull_o,
    output logic [7:0] first_o
);
    int bits = 0;
    initial pull_o = 1'b0;
    initial first_o = 8'h00;
    // First byte after a start, most significant bit first
    always @(posedge scl_i) begin
        if (bits >= 1 && bits <= 8) first_o = {first_o[6:0], sda_i};
    end
    // Start condition restarts the bit count
    always @(negedge sda_i) if (scl_i) bits = 0;
    // Every ninth low phase is the acknowledge slot
    always @(negedge scl_i) begin
        bits++;
        pull_o = ack_en_i && (bits % 9 == 0);
    end
endmodule // eeprom_model

// File: sim/tb_top.sv
// Register-level testbench of the configuration EEPROM interface
`timescale 1ns/10ps
module tb_top;
    logic                 clk_i = 1'b0;
    logic                 rst, sof, emul, rd8, a2, pull;
    logic                 scl_s, scl_oe, sda_s, sda_oe, evt;
    logic [7:0]           net_rd, host_rd, first;
    cfgrom_pkg::reg_req_s net_bus, host_bus;
    int                   failures = 0, check_count = 0, cycles = 0;
    wire scl_w = scl_oe ? scl_s : 1'b1;
    wire sda_w = (sda_oe ? sda_s : 1'b1) & ~pull;
    always #2.5 clk_i = ~clk_i;
    config_eeprom_interface config_eeprom_interface_i (.clk_i(clk_i),
        .sys_rst_i(rst), .net_bus_i(net_bus), .net_rdata_o(net_rd),
        .host_bus_i(host_bus), .host_rdata_o(host_rd), .frame_sof_i(sof),
        .emul_mode_i(emul), .read8_i(rd8), .addr2_i(a2), .scl_o(scl_s),
        .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_s),
        .sda_oe_o(sda_oe), .event_req_o(evt));
    eeprom_model eeprom_model_i (.scl_i(scl_w), .sda_i(sda_w),
        .ack_en_i(1'b0), .pull_o(pull), .first_o(first));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input bit h, input bit w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clk_i);
        #1;
        if (h) host_bus = '{w, a, d};
        else net_bus = '{w, a, d};
    endtask
    task automatic wr(input bit h, input logic [15:0] a, input logic [7:0] d);
        put(h, 1'b1, a, d);
        put(h, 1'b0, a, d);
    endtask
    task automatic rd(input bit h, input logic [15:0] a, input logic [7:0] e);
        put(h, 1'b0, a, 8'h00);
        @(posedge clk_i);
        #1;
        check(h ? host_rd : net_rd, e);
    endtask
    task automatic pulse_sof();
        @(posedge clk_i);
        #1 sof = 1'b1;
        @(posedge clk_i);
        #1 sof = 1'b0;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            complete_run();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1; sof = 1'b0; emul = 1'b0; rd8 = 1'b1; a2 = 1'b1;
        net_bus = '{1'b0, 16'h0503, 8'h00};
        host_bus = '{1'b0, 16'h0000, 8'h00};
        repeat (6) @(posedge clk_i);
        #1 rst = 1'b0;
        rd(0, 16'h0503, 8'h10);
        rd(0, 16'h0502, 8'hc0);
        wr(0, 16'h0503, 8'h03);
        rd(0, 16'h0503, 8'h30);
        wr(0, 16'h0503, 8'h01);
        rd(0, 16'h0503, 8'h30);
        wr(0, 16'h0503, 8'h00);
        rd(0, 16'h0503, 8'h10);
        wr(0, 16'h0503, 8'h02);
        rd(0, 16'h0503, 8'h50);
        wr(0, 16'h0503, 8'h00);
        wr(0, 16'h0502, 8'h01);
        rd(0, 16'h0502, 8'hc1);
        pulse_sof();
        rd(0, 16'h0502, 8'hc0);
        // Write command to an absent memory ends in a missing acknowledge
        wr(0, 16'h0502, 8'h01);
        wr(0, 16'h0503, 8'h02);
        rd(0, 16'h0503, 8'h92);
        do begin
            @(posedge clk_i);
            #1;
        end while (net_rd[7] !== 1'b0);
        check(net_rd, 8'h30);
        check(first, {cfgrom_pkg::DEV_ADDR[6:3], 4'h0});
        wr(0, 16'h0503, 8'h00);
        // Ownership hand-over between the two sides
        wr(0, 16'h0500, 8'h01);
        rd(0, 16'h0500, 8'h01);
        wr(1, 16'h0500, 8'h00);
        rd(0, 16'h0500, 8'h01);
        wr(1, 16'h0501, 8'h01);
        rd(1, 16'h0501, 8'h01);
        rd(1, 16'h0502, 8'hc1);
        wr(0, 16'h0504, 8'h55);
        rd(0, 16'h0504, 8'h00);
        wr(1, 16'h0504, 8'h66);
        rd(0, 16'h0504, 8'h66);
        wr(0, 16'h0500, 8'h03);
        rd(1, 16'h0501, 8'h00);
        wr(1, 16'h0501, 8'h01);
        rd(1, 16'h0501, 8'h00);
        wr(0, 16'h0500, 8'h00);
        // Emulated read and reload answered by the host
        emul = 1'b1;
        pulse_sof();
        rd(0, 16'h0502, 8'he0);
        wr(0, 16'h0503, 8'h01);
        rd(0, 16'h0503, 8'h91);
        check({7'h00, evt}, 8'h01);
        wr(0, 16'h0504, 8'h77);
        rd(0, 16'h0504, 8'h66);
        wr(1, 16'h0508, 8'h5a);
        wr(1, 16'h0503, 8'h01);
        rd(0, 16'h0508, 8'h5a);
        rd(0, 16'h0503, 8'h10);
        check({7'h00, evt}, 8'h00);
        wr(0, 16'h0503, 8'h04);
        rd(0, 16'h0503, 8'h94);
        wr(1, 16'h0503, 8'h20);
        rd(0, 16'h0503, 8'h30);
        wr(0, 16'h0503, 8'h00);
        rd(0, 16'h0503, 8'h10);
        // Reload acknowledged without error leaves the device loaded
        wr(0, 16'h0503, 8'h04);
        wr(1, 16'h0503, 8'h04);
        rd(0, 16'h0503, 8'h00);
        complete_run();
    end
endmodule // tb_top
